// >>> shared/card_bridge_params.svh
`ifndef CARD_BRIDGE_PARAMS_SVH
`define CARD_BRIDGE_PARAMS_SVH

// ****************************************
// Register indices and byte addressing
// ****************************************
`define RETRY_IDX 8'h90
`define CARD_IDX 8'h91
`define DEVICE_IDX 8'h92
`define FUNC1_ADDR_BIT 10
`define ADDR_W 12

// ****************************************
// Retry timeout status fields
// ****************************************
`define RT_HOST_EN 7
`define RT_CARD_EN 6
`define RT_EXP_B 5
`define RT_EXP_A 3
`define RT_EXP_HOST 1

// ****************************************
// Card signal control fields
// ****************************************
`define CC_RING_EN 7
`define CC_RSVD_HI 6
`define CC_RSVD_LO 3
`define CC_AUDIO_SEL 2
`define CC_SPK_EN 1
`define CC_IRQ_FLAG 0

// ****************************************
// Bridge device control fields and reset
// ****************************************
`define DC_PWR_LOCK 7
`define DC_LV_FORCE 6
`define DC_DIAG5 5
`define DC_RSVD4 4
`define DC_VTEST 3
`define DC_MODE_HI 2
`define DC_MODE_LO 1
`define DC_TEST0 0
`define DC_RESET 8'h66

// ****************************************
// Timing
// ****************************************
`define RETRY_LIMIT_CYCLES 32768

`endif

// >>> shared/card_bridge_pkg.sv
package card_bridge_pkg;

    // Interrupt signalling selection
    typedef enum logic [1:0] {
        PARALLEL_ONLY = 2'h0,
        MODE_RESERVED = 2'h1,
        SERIAL_LEGACY = 2'h2,
        FULL_SERIAL = 2'h3
    } int_mode_t;

    // Retry watchdog states
    typedef enum logic {
        WD_IDLE,
        WD_WAIT
    } watch_state_t;

endpackage

// >>> src/pin_sync.sv
module pin_sync #(
    parameter int W = 2
) (
    input wire logic pclk,           // Bus clock
    input wire logic presetn,        // Global reset, active low
    input wire logic [W-1:0] async_in, // Pin levels
    output logic [W-1:0] sync_out    // Synchronised levels
);

    logic [W-1:0] meta;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// >>> src/retry_watchdog.sv
module retry_watchdog #(
    parameter int LIMIT = 32768
) (
    input wire logic pclk,        // Bus clock
    input wire logic presetn,     // Global reset, active low
    input wire logic enable,      // Counter enable
    input wire logic retry_seen,  // Target answered with retry
    input wire logic reissued,    // Request was issued again
    output logic expired          // One-cycle expiry pulse
);

    card_bridge_pkg::watch_state_t state;
    logic [15:0] count;
    wire at_limit = (count == 16'(LIMIT - 1));

    // A further retry in the window is ignored; disabling drops it silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= card_bridge_pkg::WD_IDLE;
            count <= 16'h0000;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            unique case (state)
                card_bridge_pkg::WD_IDLE: begin
                    count <= 16'h0000;
                    if (enable && retry_seen) begin
                        state <= card_bridge_pkg::WD_WAIT;
                    end
                end
                card_bridge_pkg::WD_WAIT: begin
                    count <= count + 16'h0001;
                    if (!enable || reissued) begin
                        state <= card_bridge_pkg::WD_IDLE;
                    end else if (at_limit) begin
                        expired <= 1'b1;
                        state <= card_bridge_pkg::WD_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// >>> src/retry_card_device_control_regs.sv
`include "card_bridge_params.svh"
// Behaviour
// - Flag a target's retry as expired after 2^15 cycles without reissue.
// - Expiry flags stay set until a 1 is written; writing 0 keeps them.
// - Retry bit 7 enables the host retry counter; resets to 1.
// - Retry bit 6 enables the card retry counter; resets to 1, global.
// - Expiry flags: card B bit 5, card A bit 3, host bit 1; reset 0.
// - Retry bits 4, 2 and 0 always read 0.
// - Card control bit 7 enables ring indicate output; one shared copy.
// - Card control bit 2 clear routes card audio to the PWM source.
// - With audio bit set in both functions, function 0 audio is routed.
// - Speaker enable drives the XOR of both socket speaker inputs.
// - Speaker pin driven only while either function's enable is set.
// - Card control bit 0 sets on a socket interrupt; write 1 clears.
// - Power lock blocks socket power down while in D3.
// - Device bit 6 forces 3-V capable report; resets to 1, global.
// - Device bit 5 is a read/write diagnostic bit resetting to 1.
// - Device bits 2-1 select interrupt signalling mode; default 11.
// - Device control bit 4 reads 0 and ignores writes.
// - Sticky bits clear only on global reset, not on function reset.
module retry_card_device_control_regs #(
    parameter int RETRY_LIMIT = `RETRY_LIMIT_CYCLES
) (
    input wire logic pclk,                      // Bus clock
    input wire logic presetn,                   // Global reset, active low
    input wire logic function_reset,            // Non-global reset, sync
    input wire logic psel,                      // APB select
    input wire logic penable,                   // APB enable
    input wire logic pwrite,                    // APB direction
    input wire logic [`ADDR_W-1:0] paddr,       // APB byte address
    input wire logic [31:0] pwdata,             // APB write data
    output logic [31:0] prdata,                 // APB read data
    output logic pready,                        // APB ready
    output logic pslverr,                       // APB error
    input wire logic host_retry_seen,           // Host target retried us
    input wire logic host_retry_reissued,       // Host request reissued
    input wire logic [1:0] card_retry_seen,     // Card A/B target retried
    input wire logic [1:0] card_retry_reissued, // Card A/B reissued
    input wire logic [1:0] card_functional_irq, // Socket irq pulse
    input wire logic [1:0] card_ring_in,        // Socket ring pins
    input wire logic [1:0] card_audio_input,    // Socket audio pins
    input wire logic [1:0] card_speaker_input,  // Socket speaker pins
    input wire logic power_state_d3,            // Controller in D3
    input wire logic socket_power_down_request, // Software power down
    output logic socket_power_down_allowed,     // Power down granted
    output logic ring_indicate_output,          // Ring indicate pin
    output logic pwm_audio_source,              // Routed card audio
    output logic combined_speaker_output,       // Speaker data
    output logic speaker_output_enable,         // Speaker pin drive
    output logic low_voltage_capable_force,     // 3-V capable report
    output logic [1:0] interrupt_signaling_select // Interrupt mode
);

    // ****************************************
    // Register state
    // ****************************************
    logic host_retry_counter_enable;
    logic card_retry_counter_enable;
    logic host_target_retry_expired;
    logic card_target_a_retry_expired;
    logic card_target_b_retry_expired;
    logic ring_indicate_enable;
    logic [3:0] card_rsvd [2];
    logic [1:0] card_audio_routing_select;
    logic [1:0] speaker_enable;
    logic [1:0] card_functional_irq_flag;
    logic socket_power_lock;
    logic diag_bit_five;
    logic vendor_test;
    logic test_zero;
    card_bridge_pkg::int_mode_t int_mode;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic reg_hit(input logic [`ADDR_W-1:0] a, input logic [7:0] idx);
        reg_hit = (a[9:2] == idx) && (a[1:0] == 2'h0) && !a[11];
    endfunction

    // Function 1 copies sit 0x400 above function 0
    wire func_sel = paddr[`FUNC1_ADDR_BIT];
    wire hit_retry = reg_hit(paddr, `RETRY_IDX);
    wire hit_card = reg_hit(paddr, `CARD_IDX);
    wire hit_dev = reg_hit(paddr, `DEVICE_IDX);
    wire hit_any = hit_retry | hit_card | hit_dev;
    wire access = psel & penable;
    wire wr = access & pwrite & hit_any;
    wire wr_retry = wr & hit_retry;
    wire wr_card = wr & hit_card;
    wire wr_dev = wr & hit_dev;
    wire [7:0] wd = pwdata[7:0];

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & !hit_any;

    // ****************************************
    // Retry watchdogs
    // ****************************************
    wire host_expired;
    wire [1:0] card_expired;

    retry_watchdog #(.LIMIT(RETRY_LIMIT)) host_wd (
        .pclk(pclk),
        .presetn(presetn),
        .enable(host_retry_counter_enable),
        .retry_seen(host_retry_seen),
        .reissued(host_retry_reissued),
        .expired(host_expired)
    );

    // One global enable serves both card targets
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_card_wd
            retry_watchdog #(.LIMIT(RETRY_LIMIT)) card_wd (
                .pclk(pclk),
                .presetn(presetn),
                .enable(card_retry_counter_enable),
                .retry_seen(card_retry_seen[t]),
                .reissued(card_retry_reissued[t]),
                .expired(card_expired[t])
            );
        end
    endgenerate

    // ****************************************
    // Retry timeout status register
    // ****************************************
    // Set wins over a same-cycle write-one clear
    wire next_host_exp = (host_target_retry_expired & !(wr_retry & wd[`RT_EXP_HOST])) | host_expired;
    wire next_exp_a = (card_target_a_retry_expired & !(wr_retry & wd[`RT_EXP_A])) | card_expired[0];
    wire next_exp_b = (card_target_b_retry_expired & !(wr_retry & wd[`RT_EXP_B])) | card_expired[1];

    // Sticky group: only the global reset restores defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_retry_counter_enable <= 1'b1;
            card_retry_counter_enable <= 1'b1;
            host_target_retry_expired <= 1'b0;
            card_target_a_retry_expired <= 1'b0;
            card_target_b_retry_expired <= 1'b0;
        end else begin
            if (wr_retry) begin
                host_retry_counter_enable <= wd[`RT_HOST_EN];
                card_retry_counter_enable <= wd[`RT_CARD_EN];
            end
            host_target_retry_expired <= next_host_exp;
            card_target_a_retry_expired <= next_exp_a;
            card_target_b_retry_expired <= next_exp_b;
        end
    end

    // ****************************************
    // Card signal control register
    // ****************************************
    logic [1:0] next_irq;
    always_comb begin
        for (int f = 0; f < 2; f++) begin
            next_irq[f] = card_functional_irq_flag[f];
            if (wr_card && (func_sel == f[0]) && wd[`CC_IRQ_FLAG]) begin
                next_irq[f] = 1'b0;
            end
            next_irq[f] = next_irq[f] | card_functional_irq[f];
        end
    end

    // Sticky per-function bits; ring enable has one shared copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_indicate_enable <= 1'b0;
            card_audio_routing_select <= 2'h0;
            speaker_enable <= 2'h0;
            card_functional_irq_flag <= 2'h0;
        end else begin
            if (wr_card) begin
                ring_indicate_enable <= wd[`CC_RING_EN];
                card_audio_routing_select[func_sel] <= wd[`CC_AUDIO_SEL];
                speaker_enable[func_sel] <= wd[`CC_SPK_EN];
            end
            card_functional_irq_flag <= next_irq;
        end
    end

    // Reserved bits are the only state a function reset touches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_rsvd[0] <= 4'h0;
            card_rsvd[1] <= 4'h0;
        end else if (function_reset) begin
            card_rsvd[0] <= 4'h0;
            card_rsvd[1] <= 4'h0;
        end else if (wr_card) begin
            card_rsvd[func_sel] <= wd[`CC_RSVD_HI:`CC_RSVD_LO];
        end
    end

    // ****************************************
    // Bridge device control register
    // ****************************************
    // A literal cannot be bit-selected, so the default word is named first
    localparam logic [7:0] DEV_DEFAULT = `DC_RESET;

    // Shared by both functions; bit 4 has no storage at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            socket_power_lock <= DEV_DEFAULT[`DC_PWR_LOCK];
            low_voltage_capable_force <= DEV_DEFAULT[`DC_LV_FORCE];
            diag_bit_five <= DEV_DEFAULT[`DC_DIAG5];
            vendor_test <= DEV_DEFAULT[`DC_VTEST];
            int_mode <= card_bridge_pkg::FULL_SERIAL;
            test_zero <= DEV_DEFAULT[`DC_TEST0];
        end else if (wr_dev) begin
            socket_power_lock <= wd[`DC_PWR_LOCK];
            low_voltage_capable_force <= wd[`DC_LV_FORCE];
            diag_bit_five <= wd[`DC_DIAG5];
            vendor_test <= wd[`DC_VTEST];
            int_mode <= card_bridge_pkg::int_mode_t'(wd[`DC_MODE_HI:`DC_MODE_LO]);
            test_zero <= wd[`DC_TEST0];
        end
    end

    assign interrupt_signaling_select = int_mode;

    // ****************************************
    // Read multiplexer
    // ****************************************
    wire [7:0] rd_retry = {host_retry_counter_enable, card_retry_counter_enable,
        card_target_b_retry_expired, 1'b0, card_target_a_retry_expired, 1'b0,
        host_target_retry_expired, 1'b0};
    wire [7:0] rd_card = {ring_indicate_enable, card_rsvd[func_sel],
        card_audio_routing_select[func_sel], speaker_enable[func_sel],
        card_functional_irq_flag[func_sel]};
    wire [7:0] rd_dev = {socket_power_lock, low_voltage_capable_force, diag_bit_five,
        1'b0, vendor_test, int_mode, test_zero};
    wire [7:0] rd_sel = hit_retry ? rd_retry : hit_card ? rd_card : hit_dev ? rd_dev : 8'h00;

    // Read data is captured in the setup phase so it comes from a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_sel};
        end
    end

    // ****************************************
    // Socket pins
    // ****************************************
    wire [1:0] ring_s;
    wire [1:0] audio_s;
    wire [1:0] spk_s;

    pin_sync #(.W(6)) pins (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({card_ring_in, card_audio_input, card_speaker_input}),
        .sync_out({ring_s, audio_s, spk_s})
    );

    // Function 1 audio only when function 0 opts out and function 1 does not
    wire audio_from_f1 = card_audio_routing_select[0] & !card_audio_routing_select[1];
    wire next_audio = audio_from_f1 ? audio_s[1] : audio_s[0];
    wire spk_any = |speaker_enable;
    wire lock_active = socket_power_lock & power_state_d3;

    // Pin outputs are registered to keep them glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_indicate_output <= 1'b0;
            pwm_audio_source <= 1'b0;
            combined_speaker_output <= 1'b0;
            speaker_output_enable <= 1'b0;
            socket_power_down_allowed <= 1'b0;
        end else begin
            ring_indicate_output <= ring_indicate_enable & (|ring_s);
            pwm_audio_source <= next_audio;
            combined_speaker_output <= spk_any & (spk_s[0] ^ spk_s[1]);
            speaker_output_enable <= spk_any;
            socket_power_down_allowed <= socket_power_down_request & !lock_active;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup_retry;
        psel && !penable && hit_retry && !pwrite;
    endsequence

    sequence s_access_retry;
        psel && penable && hit_retry;
    endsequence

    a_expiry_sets_flag: assert property (host_expired |=> host_target_retry_expired)
        else $error("host expiry did not set flag");
    a_flag_write_one: assert property (wr_retry && wd[`RT_EXP_B] && !card_expired[1]
        |=> !card_target_b_retry_expired)
        else $error("write one did not clear card B flag");
    a_flag_write_zero: assert property (card_target_a_retry_expired && wr_retry && !wd[`RT_EXP_A]
        |=> card_target_a_retry_expired)
        else $error("write zero cleared card A flag");
    a_retry_reserved_zero: assert property (s_setup_retry ##1 s_access_retry
        |-> (prdata[4] == 1'b0) && (prdata[2] == 1'b0) && (prdata[0] == 1'b0))
        else $error("retry reserved bit read as one");
    a_ring_gated: assert property (!ring_indicate_enable |=> !ring_indicate_output)
        else $error("ring output while disabled");
    a_speaker_xor: assert property (spk_any ##1 spk_any
        |-> combined_speaker_output == ($past(spk_s[0]) ^ $past(spk_s[1])))
        else $error("speaker output is not the XOR");
    a_speaker_drive: assert property (speaker_output_enable == $past(spk_any, 1))
        else $error("speaker drive not tied to enables");
    a_irq_flag_set: assert property (card_functional_irq[0] ##1 !card_functional_irq[0]
        |-> card_functional_irq_flag[0])
        else $error("socket 0 irq flag not set");
    a_power_lock: assert property (lock_active |=> !socket_power_down_allowed)
        else $error("power down allowed under lock in D3");
    a_dev_bit4_zero: assert property (psel && penable && hit_dev && !pwrite
        |-> prdata[`DC_RSVD4] == 1'b0)
        else $error("device bit 4 read as one");

    // Forward checks: an enabled path must also let its effect through; a disabled host counter raises no expiry
    a_irq_set_one: assert property (card_functional_irq[1] |=> card_functional_irq_flag[1])
        else $error("socket 1 irq flag not set");
    a_ring_follows: assert property (ring_indicate_enable && (|ring_s) |=> ring_indicate_output)
        else $error("ring output missing while enabled");
    a_power_allowed: assert property (socket_power_down_request && !lock_active
        |=> socket_power_down_allowed)
        else $error("power down refused without lock");
    a_audio_both_set: assert property (card_audio_routing_select == 2'b11
        |=> pwm_audio_source == $past(audio_s[0]))
        else $error("audio not taken from function 0");
    a_lv_write: assert property (wr_dev |=> low_voltage_capable_force == $past(wd[`DC_LV_FORCE]))
        else $error("3-V force bit did not take write");
    a_host_count_off: assert property (!host_retry_counter_enable |=> !host_expired)
        else $error("host expiry while counter disabled");

endmodule

// >>> test/card_side_model.sv
// ********
// Host bus and socket side stimulus
// ********
module card_side_model (
    input wire logic pclk, // Bus clock
    output logic host_retry_seen, // Host retry
    output logic host_retry_reissued, // Host reissue
    output logic [1:0] card_retry_seen, // Card B/A retry
    output logic [1:0] card_retry_reissued, // Card B/A reissue
    output logic [1:0] card_functional_irq, // Socket irq
    output logic [1:0] ring, // Ring pins
    output logic [1:0] audio, // Audio pins
    output logic [1:0] spk, // Speaker pins
    output logic d3, // Controller in D3
    output logic pdn_req // Power down request
);
    timeunit 1ns;
    timeprecision 1ns;

    // Everything idle at time zero
    initial begin
        {host_retry_seen, host_retry_reissued, card_retry_seen, card_retry_reissued} = '0;
        {card_functional_irq, ring, audio, spk, d3, pdn_req} = '0;
    end

    // One-cycle retry or reissue pulse; w is {host, card B, card A}
    task automatic retry(input logic [2:0] w, input logic re);
        @(posedge pclk);
        host_retry_seen <= w[2] & !re;
        card_retry_seen <= w[1:0] & {2{!re}};
        host_retry_reissued <= w[2] & re;
        card_retry_reissued <= w[1:0] & {2{re}};
        @(posedge pclk);
        {host_retry_seen, card_retry_seen, host_retry_reissued, card_retry_reissued} <= '0;
    endtask

    // Socket interrupt is a single pulse, the flag must hold it
    task automatic irq(input logic [1:0] s);
        @(posedge pclk);
        card_functional_irq <= s;
        @(posedge pclk);
        card_functional_irq <= '0;
    endtask

    // Pin levels move on an edge; the design resynchronises them
    task automatic pins(input logic [1:0] r, input logic [1:0] a, input logic [1:0] s);
        @(posedge pclk);
        ring <= r;
        audio <= a;
        spk <= s;
    endtask

    task automatic power(input logic d, input logic q);
        @(posedge pclk);
        d3 <= d;
        pdn_req <= q;
    endtask
endmodule

// >>> test/tb.sv
`include "card_bridge_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIM = 16;
    localparam logic [11:0] RT = 12'({`RETRY_IDX, 2'b00});
    localparam logic [11:0] CC = 12'({`CARD_IDX, 2'b00});
    localparam logic [11:0] DC = 12'({`DEVICE_IDX, 2'b00});
    localparam logic [11:0] F1 = 12'(1 << `FUNC1_ADDR_BIT);
    logic pclk = 0, presetn = 0, function_reset = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, hrs, hrr, d3, pdn, pdn_ok, ring_o, pwm, spk_o, spk_en, lv;
    logic [1:0] crs, crr, cirq, ring, audio, spk, isel;
    int error_cnt = 0, checks = 0;

    // Free-running bus clock
    always #25 pclk = ~pclk;

    retry_card_device_control_regs #(.RETRY_LIMIT(LIM)) retry_card_device_control_regs_inst (
        .pclk(pclk), .presetn(presetn), .function_reset(function_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_retry_seen(hrs), .host_retry_reissued(hrr),
        .card_retry_seen(crs), .card_retry_reissued(crr), .card_functional_irq(cirq),
        .card_ring_in(ring), .card_audio_input(audio), .card_speaker_input(spk),
        .power_state_d3(d3), .socket_power_down_request(pdn), .socket_power_down_allowed(pdn_ok),
        .ring_indicate_output(ring_o), .pwm_audio_source(pwm), .combined_speaker_output(spk_o),
        .speaker_output_enable(spk_en), .low_voltage_capable_force(lv),
        .interrupt_signaling_select(isel));

    card_side_model card_side_model_inst (
        .pclk(pclk), .host_retry_seen(hrs), .host_retry_reissued(hrr), .card_retry_seen(crs),
        .card_retry_reissued(crr), .card_functional_irq(cirq), .ring(ring), .audio(audio),
        .spk(spk), .d3(d3), .pdn_req(pdn));

    // ********
    // Compare and bus tasks
    // ********
    task automatic check_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_pin(input string n, input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    // Request held from setup until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check_reg(n, {24'h0, e}, rd);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end

    // ********
    // Test sequence
    // ********
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rdc("retry", RT, 8'hC0);
        rdc("card", CC, 8'h00);
        rdc("device", DC, 8'h66);
        check_pin("lv", 2'b01, lv);
        $display("reset test done");
        card_side_model_inst.retry(3'b111, 1'b0);
        repeat (LIM + 4) @(posedge pclk);
        rdc("retry", RT, 8'hEA);
        wr(RT, 8'hD5);
        rdc("retry", RT, 8'hEA);
        wr(RT, 8'hC8);
        rdc("retry", RT, 8'hE2);
        wr(RT, 8'hE2);
        card_side_model_inst.retry(3'b100, 1'b0);
        repeat (5) @(posedge pclk);
        card_side_model_inst.retry(3'b100, 1'b1);
        repeat (LIM + 4) @(posedge pclk);
        rdc("retry", RT, 8'hC0);
        wr(RT, 8'h40);
        card_side_model_inst.retry(3'b111, 1'b0);
        repeat (LIM + 4) @(posedge pclk);
        rdc("retry", RT, 8'h68);
        wr(RT, 8'h28);
        card_side_model_inst.retry(3'b111, 1'b0);
        repeat (LIM + 4) @(posedge pclk);
        rdc("retry", RT, 8'h00);
        wr(RT, 8'hC0);
        $display("retry test done");
        // Bit 4 written as 1 must not stick; test bits 3 and 0 get only 0
        for (int m = 0; m < 4; m++) begin
            wr(DC, 8'h70 | 8'(m << 1));
            rdc("device", DC, 8'h60 | 8'(m << 1));
            check_pin("interrupt_signaling_select", 2'(m), isel);
        end
        card_side_model_inst.power(1'b1, 1'b1);
        repeat (3) @(posedge pclk);
        check_pin("pdn_ok", 2'b01, pdn_ok);
        wr(DC, 8'hA6);
        rdc("device f1", F1 | DC, 8'hA6);
        check_pin("lv", 2'b00, lv);
        check_pin("pdn_ok", 2'b00, pdn_ok);
        card_side_model_inst.power(1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        check_pin("pdn_ok", 2'b01, pdn_ok);
        $display("device test done");
        // Reserved card bits 6-3 are always written as read
        card_side_model_inst.pins(2'b01, 2'b10, 2'b01);
        repeat (5) @(posedge pclk);
        check_pin("ring", 2'b00, ring_o);
        check_pin("spk_en", 2'b00, spk_en);
        wr(CC, 8'h84);
        repeat (5) @(posedge pclk);
        check_pin("ring", 2'b01, ring_o);
        check_pin("pwm", 2'b01, pwm);
        rdc("card f1", F1 | CC, 8'h80);
        wr(F1 | CC, 8'h86);
        repeat (5) @(posedge pclk);
        check_pin("pwm", 2'b00, pwm);
        check_pin("spk_en", 2'b01, spk_en);
        check_pin("spk", 2'b01, spk_o);
        card_side_model_inst.pins(2'b01, 2'b10, 2'b11);
        repeat (5) @(posedge pclk);
        check_pin("spk", 2'b00, spk_o);
        card_side_model_inst.irq(2'b10);
        rdc("card f1", F1 | CC, 8'h87);
        rdc("card f0", CC, 8'h84);
        wr(F1 | CC, 8'h87);
        rdc("card f1", F1 | CC, 8'h86);
        card_side_model_inst.irq(2'b01);
        rdc("card f0", CC, 8'h85);
        @(posedge pclk);
        function_reset <= 1;
        @(posedge pclk);
        function_reset <= 0;
        rdc("card f0", CC, 8'h85);
        rdc("device", DC, 8'hA6);
        $display("card test done");
        apb(1'b1, 12'h24C, 8'hFF);
        check_pin("slverr", 2'b01, err);
        apb(1'b0, 12'h241, 8'h00);
        check_pin("slverr", 2'b01, err);
        check_reg("unmapped", 32'h0000_0000, rd);
        rdc("retry", RT, 8'hC0);
        $display("unmapped test done");
        complete_run();
    end
endmodule
